/* File: design/rce_pkg.sv */
package rce_pkg;

  // ==========================================
  // Register offsets
  localparam logic [7:0] RCE_OFS_BOOST    = 8'h03;
  localparam logic [7:0] RCE_OFS_LOWRATE  = 8'h0D;
  localparam logic [7:0] RCE_OFS_POWER    = 8'h13;
  localparam logic [7:0] RCE_OFS_OVERRIDE = 8'h2D;
  localparam logic [7:0] RCE_OFS_ROUTE    = 8'h31;
  localparam logic [7:0] RCE_OFS_BOOST_RB = 8'h52;
  localparam logic [7:0] RCE_OFS_STATUS   = 8'h54;
  localparam logic [7:0] RCE_OFS_MASK     = 8'h56;

  // ==========================================
  // Reset values
  localparam logic [7:0] RCE_RST_BOOST    = 8'h80;
  localparam logic [7:0] RCE_RST_LOWRATE  = 8'h00;
  localparam logic [7:0] RCE_RST_POWER    = 8'h90;
  localparam logic [7:0] RCE_RST_OVERRIDE = 8'h88;
  localparam logic [7:0] RCE_RST_ROUTE    = 8'h00;
  localparam logic [7:0] RCE_RST_MASK     = 8'h00;

  // ==========================================
  // Field positions
  localparam int RCE_BIT_AUTO_BYPASS   = 0;
  localparam int RCE_BIT_IN0_SD_PD     = 6;
  localparam int RCE_BIT_IN1_SD_PD     = 5;
  localparam int RCE_BIT_EQ_PD         = 3;
  localparam int RCE_BIT_STAGE_BYPASS  = 1;
  localparam int RCE_BIT_OVERRIDE      = 3;
  localparam int RCE_BIT_ROUTE_HI      = 1;
  localparam int RCE_BIT_ROUTE_LO      = 0;
  // Status and mask share one layout
  localparam int RCE_EV_LOCK      = 6;
  localparam int RCE_EV_DET1      = 5;
  localparam int RCE_EV_DET0      = 4;
  localparam int RCE_EV_EYE       = 3;
  localparam int RCE_EV_LOCK_LOSS = 2;
  localparam int RCE_EV_LOSS1     = 1;
  localparam int RCE_EV_LOSS0     = 0;
  localparam int RCE_EV_SIGDET    = 7;

  // Host access phases
  typedef enum logic [1:0] {RCE_IDLE, RCE_WRITE, RCE_READ} rce_acc_t;

endpackage : rce_pkg

/* File: design/rce_event_flags.sv */
`timescale 1ns/1ns
// ==========================================
// Sticky interrupt flags, cleared by read
module rce_event_flags
  import rce_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] event_pulse,
  input  wire logic         clear_all,
  output logic      [W-1:0] flags_reg
);

  logic [W-1:0] flags_next;

  // Set wins over a read clear in the same cycle
  assign flags_next = (clear_all ? '0 : flags_reg) | event_pulse;

  // Flag storage
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    (event_pulse != '0) |=> ((flags_reg & $past(event_pulse)) == $past(event_pulse)))
    else $error("event lost against clear");

endmodule : rce_event_flags

/* File: design/rce_eq_control.sv */
`timescale 1ns/1ns
// ==========================================
// Equalizer boost, bypass and power decode
module rce_eq_control
  import rce_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] boost_written,
  input  wire logic [7:0] lowrate_cfg,
  input  wire logic [7:0] power_cfg,
  input  wire logic [7:0] override_cfg,
  input  wire logic [1:0] route_sel,
  input  wire logic       rate_is_270m,
  input  wire logic       adapt_active,
  input  wire logic [7:0] adapt_boost,
  output logic      [7:0] equalizer_boost_levels_reg,
  output logic            eq_bypass_reg,
  output logic            late_stage_bypass_reg,
  output logic            eq0_powerdown_reg,
  output logic            eq1_powerdown_reg,
  output logic            in0_sd_powerdown_reg,
  output logic            in1_sd_powerdown_reg
);

  logic       use_second;
  logic       boost_override;
  logic       manual_bypass_alias;
  logic       low_rate_auto_bypass;
  logic [7:0] boost_next;
  logic       bypass_next;

  // Decode of control fields
  assign use_second           = route_sel[RCE_BIT_ROUTE_HI];
  assign boost_override       = override_cfg[RCE_BIT_OVERRIDE];
  assign manual_bypass_alias  = power_cfg[RCE_BIT_STAGE_BYPASS];
  assign low_rate_auto_bypass = lowrate_cfg[RCE_BIT_AUTO_BYPASS];
  // Adapted values when adapting, written when overridden, else hold
  assign boost_next  = adapt_active   ? adapt_boost   :
                       boost_override ? boost_written : equalizer_boost_levels_reg;
  // Manual bypass dominates; auto bypass only at the low rate
  assign bypass_next = manual_bypass_alias ||
                       (low_rate_auto_bypass && rate_is_270m);

  // Registered equalizer controls
  always_ff @(posedge clk) begin
    if (rst) begin
      equalizer_boost_levels_reg          <= RCE_RST_BOOST;
      eq_bypass_reg         <= 1'b0;
      late_stage_bypass_reg <= 1'b0;
      eq0_powerdown_reg     <= 1'b0;
      eq1_powerdown_reg     <= 1'b1;
      in0_sd_powerdown_reg  <= 1'b0;
      in1_sd_powerdown_reg  <= 1'b0;
    end else begin
      equalizer_boost_levels_reg          <= boost_next;
      eq_bypass_reg         <= bypass_next;
      late_stage_bypass_reg <= power_cfg[RCE_BIT_STAGE_BYPASS];
      eq0_powerdown_reg     <= use_second || power_cfg[RCE_BIT_EQ_PD];
      eq1_powerdown_reg     <= !use_second || power_cfg[RCE_BIT_EQ_PD];
      in0_sd_powerdown_reg  <= power_cfg[RCE_BIT_IN0_SD_PD];
      in1_sd_powerdown_reg  <= power_cfg[RCE_BIT_IN1_SD_PD];
    end
  end

  unsel_off_a: assert property (@(posedge clk) disable iff (rst)
    ##1 ($past(use_second) ? eq0_powerdown_reg : eq1_powerdown_reg))
    else $error("unselected equalizer powered");
  sel_pd_a: assert property (@(posedge clk) disable iff (rst)
    power_cfg[RCE_BIT_EQ_PD] |=> (eq0_powerdown_reg && eq1_powerdown_reg))
    else $error("selected equalizer not powered down");
  man_bypass_a: assert property (@(posedge clk) disable iff (rst)
    manual_bypass_alias |=> (eq_bypass_reg && late_stage_bypass_reg))
    else $error("manual bypass ignored");
  auto_bypass_a: assert property (@(posedge clk) disable iff (rst)
    (!manual_bypass_alias && low_rate_auto_bypass && rate_is_270m) |=> eq_bypass_reg)
    else $error("low rate bypass missing");
  no_auto_a: assert property (@(posedge clk) disable iff (rst)
    (!manual_bypass_alias && !low_rate_auto_bypass) |=> !eq_bypass_reg)
    else $error("bypass without cause");
  override_a: assert property (@(posedge clk) disable iff (rst)
    (!adapt_active && boost_override) |=> (equalizer_boost_levels_reg == $past(boost_written)))
    else $error("override boost not applied");
  hold_a: assert property (@(posedge clk) disable iff (rst)
    (!adapt_active && !boost_override) |=> $stable(equalizer_boost_levels_reg))
    else $error("boost moved without override");

endmodule : rce_eq_control

/* File: design/rce_regs.sv */
`timescale 1ns/1ns
// ==========================================
// Per-channel mask and equalizer register bank
module rce_regs
  import rce_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port from the serial management decoder
  input  wire logic       channel_bank_select,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_reg,
  output logic            reg_rvalid_reg,
  // Event pulses, one cycle each
  input  wire logic       cdr_lock_event,
  input  wire logic       input1_detect_event,
  input  wire logic       input0_detect_event,
  input  wire logic       eye_threshold_event,
  input  wire logic       cdr_lock_loss_event,
  input  wire logic       input1_loss_event,
  input  wire logic       input0_loss_event,
  input  wire logic       selected_detect_change,
  // Equalizer status from the analog side
  input  wire logic       rate_is_270m,
  input  wire logic       adapt_active,
  input  wire logic [7:0] adapt_boost,
  // Outputs
  output logic            irq_reg,
  output logic      [7:0] equalizer_boost_levels_reg,
  output logic            eq_bypass_reg,
  output logic            late_stage_bypass_reg,
  output logic            eq0_powerdown_reg,
  output logic            eq1_powerdown_reg,
  output logic            in0_sd_powerdown_reg,
  output logic            in1_sd_powerdown_reg
);

  // ==========================================
  // Storage
  logic [7:0] boost_written_reg;
  logic [7:0] lowrate_reg;
  logic [7:0] power_reg;
  logic [7:0] override_reg;
  logic [7:0] route_reg;
  logic [7:0] mask_reg;
  logic [7:0] status_flags;
  logic [7:0] event_vec;
  logic [7:0] rdata_next;
  logic       irq_next;
  logic       wr_ok;
  logic       rd_ok;
  logic       status_read;
  logic [7:0] boost_written_next;

  // Access only while the channel bank is selected
  assign wr_ok       = reg_wr && channel_bank_select;
  assign rd_ok       = reg_rd && channel_bank_select;
  assign status_read = rd_ok && (reg_addr == RCE_OFS_STATUS);

  // Event vector in status layout
  assign event_vec[RCE_EV_SIGDET]    = selected_detect_change;
  assign event_vec[RCE_EV_LOCK]      = cdr_lock_event;
  assign event_vec[RCE_EV_DET1]      = input1_detect_event;
  assign event_vec[RCE_EV_DET0]      = input0_detect_event;
  assign event_vec[RCE_EV_EYE]       = eye_threshold_event;
  assign event_vec[RCE_EV_LOCK_LOSS] = cdr_lock_loss_event;
  assign event_vec[RCE_EV_LOSS1]     = input1_loss_event;
  assign event_vec[RCE_EV_LOSS0]     = input0_loss_event;

  // Interrupt is any masked flag; bit 7 has no enable and reads as zero
  assign irq_next = |(status_flags & mask_reg);

  // Write data or adaptation result into the boost fields
  assign boost_written_next =
    (wr_ok && reg_addr == RCE_OFS_BOOST) ? reg_wdata :
    adapt_active                         ? adapt_boost : boost_written_reg;

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      RCE_OFS_BOOST:    rdata_next = boost_written_reg;
      RCE_OFS_LOWRATE:  rdata_next = lowrate_reg;
      RCE_OFS_POWER:    rdata_next = power_reg;
      RCE_OFS_OVERRIDE: rdata_next = override_reg;
      RCE_OFS_ROUTE:    rdata_next = route_reg;
      RCE_OFS_BOOST_RB: rdata_next = equalizer_boost_levels_reg;
      RCE_OFS_STATUS:   rdata_next = status_flags;
      RCE_OFS_MASK:     rdata_next = mask_reg;
      default:          rdata_next = 8'h00;
    endcase
  end

  // Boost field register
  always_ff @(posedge clk) begin
    if (rst) begin
      boost_written_reg <= RCE_RST_BOOST;
    end else begin
      boost_written_reg <= boost_written_next;
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      lowrate_reg  <= RCE_RST_LOWRATE;
      power_reg    <= RCE_RST_POWER;
      override_reg <= RCE_RST_OVERRIDE;
      route_reg    <= RCE_RST_ROUTE;
      mask_reg     <= RCE_RST_MASK;
    end else if (wr_ok) begin
      if (reg_addr == RCE_OFS_LOWRATE)  lowrate_reg  <= reg_wdata;
      if (reg_addr == RCE_OFS_POWER)    power_reg    <= reg_wdata;
      if (reg_addr == RCE_OFS_OVERRIDE) override_reg <= reg_wdata;
      if (reg_addr == RCE_OFS_ROUTE)    route_reg    <= reg_wdata;
      if (reg_addr == RCE_OFS_MASK)     mask_reg     <= {1'b0, reg_wdata[6:0]};
    end
  end

  // Read answer and interrupt output
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_reg  <= 8'h00;
      reg_rvalid_reg <= 1'b0;
      irq_reg        <= 1'b0;
    end else begin
      reg_rdata_reg  <= rd_ok ? rdata_next : reg_rdata_reg;
      reg_rvalid_reg <= rd_ok;
      irq_reg        <= irq_next;
    end
  end

  // ==========================================
  // Submodules
  rce_event_flags #(.W(8)) u_flags (
    .clk         (clk),
    .rst         (rst),
    .event_pulse (event_vec),
    .clear_all   (status_read),
    .flags_reg   (status_flags)
  );

  rce_eq_control u_eq (
    .clk                   (clk),
    .rst                   (rst),
    .boost_written         (boost_written_reg),
    .lowrate_cfg           (lowrate_reg),
    .power_cfg             (power_reg),
    .override_cfg          (override_reg),
    .route_sel             (route_reg[RCE_BIT_ROUTE_HI:RCE_BIT_ROUTE_LO]),
    .rate_is_270m          (rate_is_270m),
    .adapt_active          (adapt_active),
    .adapt_boost           (adapt_boost),
    .equalizer_boost_levels_reg          (equalizer_boost_levels_reg),
    .eq_bypass_reg         (eq_bypass_reg),
    .late_stage_bypass_reg (late_stage_bypass_reg),
    .eq0_powerdown_reg     (eq0_powerdown_reg),
    .eq1_powerdown_reg     (eq1_powerdown_reg),
    .in0_sd_powerdown_reg  (in0_sd_powerdown_reg),
    .in1_sd_powerdown_reg  (in1_sd_powerdown_reg)
  );

  // ==========================================
  // Checks
  sequence lock_flagged_s;
    status_flags[RCE_EV_LOCK] && mask_reg[RCE_EV_LOCK];
  endsequence

  lock_mask_a: assert property (@(posedge clk) disable iff (rst)
    lock_flagged_s |=> irq_reg)
    else $error("lock interrupt not raised");
  detect_mask_a: assert property (@(posedge clk) disable iff (rst)
    ((status_flags[RCE_EV_DET1] && mask_reg[RCE_EV_DET1]) ||
     (status_flags[RCE_EV_DET0] && mask_reg[RCE_EV_DET0])) |=> irq_reg)
    else $error("detect interrupt not raised");
  eye_mask_a: assert property (@(posedge clk) disable iff (rst)
    (status_flags[RCE_EV_EYE] && mask_reg[RCE_EV_EYE]) |=> irq_reg)
    else $error("eye interrupt not raised");
  loss_lock_a: assert property (@(posedge clk) disable iff (rst)
    (status_flags[RCE_EV_LOCK_LOSS] && mask_reg[RCE_EV_LOCK_LOSS]) |=> irq_reg)
    else $error("lock loss interrupt not raised");
  signal_loss_a: assert property (@(posedge clk) disable iff (rst)
    ((status_flags[RCE_EV_LOSS1] && mask_reg[RCE_EV_LOSS1]) ||
     (status_flags[RCE_EV_LOSS0] && mask_reg[RCE_EV_LOSS0])) |=> irq_reg)
    else $error("loss interrupt not raised");
  masked_quiet_a: assert property (@(posedge clk) disable iff (rst)
    ((status_flags & mask_reg) == 8'h00) |=> !irq_reg)
    else $error("interrupt without enabled flag");
  read_clear_a: assert property (@(posedge clk) disable iff (rst)
    (status_read && event_vec == 8'h00) |=> (status_flags == 8'h00))
    else $error("status not cleared by read");
  readback_a: assert property (@(posedge clk) disable iff (rst)
    (rd_ok && reg_addr == RCE_OFS_BOOST_RB) |=> (reg_rdata_reg == $past(equalizer_boost_levels_reg)))
    else $error("driven boost readback wrong");
  bank_gate_a: assert property (@(posedge clk) disable iff (rst)
    !channel_bank_select |=> (!reg_rvalid_reg && $stable(mask_reg)))
    else $error("access without channel bank");

endmodule : rce_regs

/* File: sim/rce_host.sv */
`timescale 1ns/1ns
// ==========================================
// Host side of the register port
module rce_host (
  input  wire logic       clk,
  output logic            channel_bank_select,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_reg,
  input  wire logic       reg_rvalid_reg
);
  // Idle lines at time zero
  initial begin
    channel_bank_select = 1'b0;
    reg_wr              = 1'b0;
    reg_rd              = 1'b0;
    reg_addr            = 8'h00;
    reg_wdata           = 8'h00;
  end

  // One write; bank select settles a cycle ahead of the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
    @(negedge clk);
    channel_bank_select = sel;
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a; // Released lines carry no stale value
    reg_wdata = ~d;
  endtask : wr

  // One read; data taken in the single cycle that rvalid stands
  task automatic rd(input logic [7:0] a, input logic sel, output logic [7:0] d,
                    output logic ok);
    int n;
    ok = 1'b0;
    d  = 8'h00;
    @(negedge clk);
    channel_bank_select = sel;
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 3 && !ok; n++) begin
      if (reg_rvalid_reg === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata_reg;
      end else begin
        @(negedge clk);
      end
    end
  endtask : rd
endmodule : rce_host

/* File: sim/rce_regs_tb.sv */
`timescale 1ns/1ns
// ==========================================
// Bench for the mask and equalizer bank
module rce_regs_tb import rce_pkg::*; ;
  logic       clk, rst, rate_is_270m, adapt_active;
  logic [7:0] adapt_boost, ev, v, s, m, rdv;
  logic       channel_bank_select, reg_wr, reg_rd, reg_rvalid_reg, ok, exp;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_reg, equalizer_boost_levels_reg;
  logic       irq_reg, eq_bypass_reg, late_stage_bypass_reg;
  logic       eq0_powerdown_reg, eq1_powerdown_reg, in0_sd_powerdown_reg, in1_sd_powerdown_reg;
  int         fail_count, n_tests, i, b, k;
  int         cycles = 0;
  integer     seed = 32'hae98ec67;
  logic [7:0] ra [8] = '{RCE_OFS_BOOST, RCE_OFS_LOWRATE, RCE_OFS_POWER, RCE_OFS_OVERRIDE,
                         RCE_OFS_ROUTE, RCE_OFS_MASK, RCE_OFS_STATUS, 8'h7F};
  logic [7:0] rv [8] = '{8'h80, 8'h00, 8'h90, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00};

  // ==========================================
  // Clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================
  // Design and host
  rce_regs dut (.clk(clk), .rst(rst), .channel_bank_select(channel_bank_select),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg),
    .cdr_lock_event(ev[RCE_EV_LOCK]), .input1_detect_event(ev[RCE_EV_DET1]),
    .input0_detect_event(ev[RCE_EV_DET0]), .eye_threshold_event(ev[RCE_EV_EYE]),
    .cdr_lock_loss_event(ev[RCE_EV_LOCK_LOSS]), .input1_loss_event(ev[RCE_EV_LOSS1]),
    .input0_loss_event(ev[RCE_EV_LOSS0]), .selected_detect_change(ev[RCE_EV_SIGDET]),
    .rate_is_270m(rate_is_270m), .adapt_active(adapt_active), .adapt_boost(adapt_boost),
    .irq_reg(irq_reg), .equalizer_boost_levels_reg(equalizer_boost_levels_reg), .eq_bypass_reg(eq_bypass_reg),
    .late_stage_bypass_reg(late_stage_bypass_reg), .eq0_powerdown_reg(eq0_powerdown_reg),
    .eq1_powerdown_reg(eq1_powerdown_reg), .in0_sd_powerdown_reg(in0_sd_powerdown_reg),
    .in1_sd_powerdown_reg(in1_sd_powerdown_reg));
  rce_host host (.clk(clk), .channel_bank_select(channel_bank_select), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg));

  // ==========================================
  // Shared helpers
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] expv);
    n_tests++;
    if (seen !== expv) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, expv, seen);
    end
  endtask : check

  task automatic rdc(input logic [7:0] a, input logic [7:0] expv);
    host.rd(a, 1'b1, rdv, ok);
    check("rvalid", {7'h00, ok}, 8'h01);
    check("rdata", rdv, expv);
  endtask : rdc

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask : settle

  // One-cycle event pulse, returns when irq has had time to follow
  task automatic pulse(input int bit_no);
    @(negedge clk);
    ev = 8'h01 << bit_no;
    @(negedge clk);
    ev = 8'h00;
    @(negedge clk);
  endtask : pulse

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // ==========================================
  // Main sequence
  initial begin
    rst          = 1'b1;
    rate_is_270m = 1'b0;
    adapt_active = 1'b0;
    adapt_boost  = 8'h00;
    ev           = 8'h00;
    fail_count   = 0;
    n_tests      = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // Reset values and an unmapped place
    for (i = 0; i < 8; i++) rdc(ra[i], rv[i]);
    check("boost_rst", equalizer_boost_levels_reg, 8'h80);
    check("eq1_pd_rst", {7'h00, eq1_powerdown_reg}, 8'h01);
    // Mask bit 7 is not held
    host.wr(RCE_OFS_MASK, 8'hFF, 1'b1);
    rdc(RCE_OFS_MASK, 8'h7F);
    // Every event with its own mask bit written (bit 7 is not held), then with only the others set
    for (b = 0; b < 8; b++) begin
      for (k = 0; k < 2; k++) begin
        m = (k == 0) ? (8'h01 << b) : (~(8'h01 << b) & 8'h7F);
        host.wr(RCE_OFS_MASK, m, 1'b1);
        pulse(b);
        exp = (b < 7) && (k == 0);
        check("irq", {7'h00, irq_reg}, {7'h00, exp});
        rdc(RCE_OFS_STATUS, 8'h01 << b);
        settle();
        check("irq_clear", {7'h00, irq_reg}, 8'h00);
      end
    end
    // Bank not selected: write ignored, read unanswered
    host.wr(RCE_OFS_MASK, 8'h55, 1'b0);
    host.rd(RCE_OFS_MASK, 1'b0, rdv, ok);
    check("refused_rd", {7'h00, ok}, 8'h00);
    rdc(RCE_OFS_MASK, 8'h7F);
    // Boost with override on, then off, then adaptation
    v = 8'($random(seed));
    host.wr(RCE_OFS_BOOST, v, 1'b1);
    settle();
    check("boost", equalizer_boost_levels_reg, v);
    rdc(RCE_OFS_BOOST_RB, v);
    host.wr(RCE_OFS_OVERRIDE, 8'h80, 1'b1);
    host.wr(RCE_OFS_BOOST, ~v, 1'b1);
    settle();
    check("boost_hold", equalizer_boost_levels_reg, v);
    rdc(RCE_OFS_BOOST, ~v);
    adapt_boost  = 8'($random(seed));
    adapt_active = 1'b1;
    settle();
    check("adapt", equalizer_boost_levels_reg, adapt_boost);
    rdc(RCE_OFS_BOOST, adapt_boost);
    rdc(RCE_OFS_BOOST_RB, adapt_boost);
    adapt_active = 1'b0;
    // Every mix of auto bypass, low rate and manual bypass
    for (i = 0; i < 8; i++) begin
      host.wr(RCE_OFS_LOWRATE, {7'h00, i[0]}, 1'b1);
      host.wr(RCE_OFS_POWER, {6'h24, i[2], 1'b0}, 1'b1);
      rate_is_270m = i[1];
      settle();
      check("bypass", {7'h00, eq_bypass_reg}, {7'h00, i[2] | (i[0] & i[1])});
      check("late", {7'h00, late_stage_bypass_reg}, {7'h00, i[2]});
    end
    // Every route code with power down on and off, random detector bits
    for (i = 0; i < 8; i++) begin
      s = 8'($random(seed)) & 8'h60;
      m = 8'h90 | s | {4'h0, i[2], 3'h0};
      host.wr(RCE_OFS_ROUTE, {6'h00, i[1:0]}, 1'b1);
      host.wr(RCE_OFS_POWER, m, 1'b1);
      settle();
      check("eq0_pd", {7'h00, eq0_powerdown_reg}, {7'h00, i[1] | i[2]});
      check("eq1_pd", {7'h00, eq1_powerdown_reg}, {7'h00, !i[1] | i[2]});
      check("sd_pd", {6'h00, in0_sd_powerdown_reg, in1_sd_powerdown_reg},
            {6'h00, s[6], s[5]});
      rdc(RCE_OFS_POWER, m);
    end
    finish_test();
  end
endmodule : rce_regs_tb
